// File: inc/mcu_clk_pkg.sv
// Constants, field layouts and types for the microcontroller clock and reset output block
package mcu_clk_pkg;

	// Register bus
	localparam int          DATA_W             = 8;
	localparam logic [7:0]  ADDR_CLK_CTRL      = 8'h00;
	localparam logic [7:0]  ADDR_MODE_CTRL     = 8'h01;
	localparam logic [7:0]  ADDR_GP_CTRL       = 8'h02;
	localparam logic [7:0]  ADDR_INT_STATUS_A  = 8'h03;
	localparam logic [7:0]  ADDR_INT_STATUS_B  = 8'h04;
	localparam logic [7:0]  ADDR_STATUS        = 8'h05;
	localparam logic [7:0]  READ_ZERO          = 8'h00;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} bus_req_t;

	// Clock control register layout, low bits first: mclk, clkt, enlfc, x32k_sel
	typedef struct packed {
		logic       x32k_sel;
		logic       enlfc;
		logic [1:0] clkt;
		logic [2:0] mclk;
	} clk_ctrl_t;

	localparam int          CLK_CTRL_W         = 7;
	localparam logic [2:0]  MCLK_FULL_SEL      = 3'h0;
	localparam logic [2:0]  MCLK_1MHZ_SEL      = 3'h6;
	localparam logic [2:0]  MCLK_LF_SEL        = 3'h7;
	localparam clk_ctrl_t   CLK_CTRL_RST       = '{x32k_sel: 1'b0, enlfc: 1'b0,
		clkt: 2'h0, mclk: MCLK_1MHZ_SEL};

	// Mode control bits
	localparam int          MODE_SLEEP_BIT     = 0;
	localparam int          MODE_SOFT_RST_BIT  = 1;

	// General-purpose pin function enables, 1 = default function
	localparam int          GP_A_BIT           = 0;
	localparam int          GP_B_BIT           = 1;
	localparam int          GP_C_BIT           = 2;
	localparam logic [2:0]  GP_CTRL_RST        = 3'h7;

	// Status register bits
	localparam int          STAT_XTAL_BIT      = 2;
	localparam int          STAT_LF_BIT        = 3;
	localparam int          STAT_IRQ_BIT       = 4;
	localparam int          STAT_RST_BIT       = 5;

	// Half period of the divided clock in core cycles, per select value
	localparam int          DIV_W              = 8;
	localparam logic [7:0]  HALF_PERIOD [8]    = '{8'h01, 8'h02, 8'h03, 8'h06,
		8'h08, 8'h0A, 8'h0C, 8'h01};

	// Extra output cycles before the clock stops, per tail setting
	localparam logic [7:0]  TAIL_CYCLES [4]    = '{8'h00, 8'h08, 8'h10, 8'h20};

	// Timing
	localparam int          CORE_CLK_MHZ       = 25;
	localparam int          SOFT_RESET_DURATION_NS = 2000;
	localparam int          SOFT_RESET_CYCLES  =
		(SOFT_RESET_DURATION_NS * CORE_CLK_MHZ + 999) / 1000;
	localparam int          SOFT_CNT_W         = 12;

	typedef enum logic [1:0] {
		ST_RUN   = 2'b00,
		ST_TAIL  = 2'b01,
		ST_SLEEP = 2'b10
	} mode_state_t;

	typedef enum logic [1:0] {
		SRC_OFF  = 2'b00,
		SRC_XTAL = 2'b01,
		SRC_LF   = 2'b10
	} clk_src_t;

endpackage

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         resetn,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	for (genvar i = 0; i < W; i++)
	begin : g_bit
		always_ff @(posedge core_clk or negedge resetn)
		begin
			if (!resetn)
			begin
				meta_q[i]   <= 1'b0;
				sync_out[i] <= 1'b0;
			end
			else
			begin
				meta_q[i]   <= async_in[i];
				sync_out[i] <= meta_q[i];
			end
		end
	end
endmodule

// File: rtl/mcu_clock_and_reset_output.sv
// Microcontroller clock output, sleep gating and reset distribution to general-purpose pins
//
// Overview of operation
// - Three-bit clock select chooses one of eight microcontroller clock frequencies.
// - All choices except the low-frequency one divide the crystal clock.
// - Low-frequency clock comes from the RC oscillator or 32 kHz crystal, as selected.
// - After reset the third pin carries the microcontroller clock at 1 MHz.
// - Select 000 gives the fastest clock, half the crystal rate, when awake.
// - Low-frequency enable in sleep outputs the selected low-frequency clock (RC or 32 kHz crystal), ignoring select.
// - Crystal oscillator is switched off in sleep.
// - Without low-frequency enable the clock output stops in sleep.
// - Two-bit tail field adds extra clock cycles after sleep entry before stopping.
// - A pending interrupt keeps the clock running in every mode.
// - Sleep entry waits until the pending interrupt has been read.
// - Any reset event returns the clock control, mode and pin control registers to their defaults.
// - A register write requests software reset, held for a fixed duration.
// - Supply drop asserts reset until power-on-ready returns.
// - First pin carries the active-level reset by default.
// - Second pin carries the inverted reset by default.
`timescale 1ns/1ps
module mcu_clock_and_reset_output
	import mcu_clk_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              resetn,
	input  wire bus_req_t          bus_req,
	output logic      [DATA_W-1:0] rd_data_q,
	input  wire logic [DATA_W-1:0] int_status_a,
	input  wire logic [DATA_W-1:0] int_status_b,
	input  wire logic              irq_pending,
	output logic                   int_status_a_rd_q,
	output logic                   int_status_b_rd_q,
	input  wire logic              rc_32k_clk,
	input  wire logic              xtal_32k_clk,
	input  wire logic              por_ready,
	input  wire logic              supply_low,
	output logic                   xtal_en_q,
	output logic                   chip_rst_q,
	output logic                   gp_pin_a_q,
	output logic                   gp_pin_b_q,
	output logic                   gp_pin_c_q
);
	localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_LOAD = SOFT_CNT_W'(SOFT_RESET_CYCLES);
	localparam logic [SOFT_CNT_W-1:0] SOFT_CNT_ZERO = '0;
	localparam logic [DIV_W-1:0]      DIV_ONE       = 8'h01;
	localparam logic [7:0]            TAIL_ZERO     = 8'h00;

	// Synchronised pins: rc, crystal 32k, power-on-ready, supply drop
	logic [3:0] pins_s;
	logic       rc_s;
	logic       x32_s;
	logic       por_ok_s;
	logic       drop_s;

	pin_sync #(.W(4)) u_pin_sync (
		.core_clk (core_clk),
		.resetn   (resetn),
		.async_in ({supply_low, por_ready, xtal_32k_clk, rc_32k_clk}),
		.sync_out (pins_s)
	);

	assign rc_s     = pins_s[0];
	assign x32_s    = pins_s[1];
	assign por_ok_s = pins_s[2];
	assign drop_s   = pins_s[3];

	// Registers
	clk_ctrl_t                clk_ctrl_q;
	logic                     sleep_req_q;
	logic [2:0]               gp_ctrl_q;
	logic                     drop_q;
	logic [SOFT_CNT_W-1:0]    soft_cnt_q;
	logic                     soft_req;
	mode_state_t              state_q;
	mode_state_t              state_d;
	clk_src_t                 src_q;
	clk_src_t                 src_want;
	logic [DIV_W-1:0]         half_q;
	logic [DIV_W-1:0]         div_cnt_q;
	logic                     mcu_clk_q;
	logic                     lf_sel_q;
	logic                     lf_now;
	logic                     lf_prev_q;
	logic                     lf_rise;
	logic                     lf_fall;
	logic                     xtal_toggle;
	logic                     mcu_rise;
	logic [7:0]               tail_cnt_q;
	logic [7:0]               status;

	// Reset sources
	assign soft_req = bus_req.wr && (bus_req.addr == ADDR_MODE_CTRL)
		&& bus_req.wdata[MODE_SOFT_RST_BIT];

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			drop_q <= 1'b0;
		else if (drop_s)
			drop_q <= 1'b1;
		else if (por_ok_s)
			drop_q <= 1'b0;
	end

	// Counter is kept out of the chip reset so the pulse outlasts the reset it causes
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			soft_cnt_q <= SOFT_CNT_ZERO;
		else if (soft_req)
			soft_cnt_q <= SOFT_CNT_LOAD;
		else if (soft_cnt_q != SOFT_CNT_ZERO)
			soft_cnt_q <= soft_cnt_q - 1'b1;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			chip_rst_q <= 1'b1;
		else
			chip_rst_q <= !por_ok_s || drop_s || drop_q || soft_req
				|| (soft_cnt_q != SOFT_CNT_ZERO);
	end

	// Software registers
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clk_ctrl_q  <= CLK_CTRL_RST;
			sleep_req_q <= 1'b0;
			gp_ctrl_q   <= GP_CTRL_RST;
		end
		else if (chip_rst_q)
		begin
			clk_ctrl_q  <= CLK_CTRL_RST;
			sleep_req_q <= 1'b0;
			gp_ctrl_q   <= GP_CTRL_RST;
		end
		else if (bus_req.wr)
		begin
			case (bus_req.addr)
				ADDR_CLK_CTRL:  clk_ctrl_q  <= clk_ctrl_t'(bus_req.wdata[CLK_CTRL_W-1:0]);
				ADDR_MODE_CTRL: sleep_req_q <= bus_req.wdata[MODE_SLEEP_BIT];
				ADDR_GP_CTRL:   gp_ctrl_q   <= bus_req.wdata[2:0];
				default:        ;
			endcase
		end
	end

	// Read path; interrupt status reads also acknowledge the interrupt block
	always_comb
	begin
		status                = READ_ZERO;
		status[1:0]           = state_q;
		status[STAT_XTAL_BIT] = xtal_en_q;
		status[STAT_LF_BIT]   = (src_q == SRC_LF);
		status[STAT_IRQ_BIT]  = irq_pending;
		status[STAT_RST_BIT]  = chip_rst_q;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rd_data_q         <= READ_ZERO;
			int_status_a_rd_q <= 1'b0;
			int_status_b_rd_q <= 1'b0;
		end
		else
		begin
			int_status_a_rd_q <= bus_req.rd && (bus_req.addr == ADDR_INT_STATUS_A);
			int_status_b_rd_q <= bus_req.rd && (bus_req.addr == ADDR_INT_STATUS_B);
			if (!bus_req.rd)
				rd_data_q <= READ_ZERO;
			else
			begin
				case (bus_req.addr)
					ADDR_CLK_CTRL:     rd_data_q <= {1'b0, clk_ctrl_q};
					ADDR_MODE_CTRL:    rd_data_q <= {7'h00, sleep_req_q};
					ADDR_GP_CTRL:      rd_data_q <= {5'h00, gp_ctrl_q};
					ADDR_INT_STATUS_A: rd_data_q <= int_status_a;
					ADDR_INT_STATUS_B: rd_data_q <= int_status_b;
					ADDR_STATUS:       rd_data_q <= status;
					default:           rd_data_q <= READ_ZERO;
				endcase
			end
		end
	end

	// Mode sequencing
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_RUN:
			begin
				// Sleep entry held off while the interrupt is unread
				if (sleep_req_q && !irq_pending)
				begin
					if (clk_ctrl_q.enlfc || (TAIL_CYCLES[clk_ctrl_q.clkt] == TAIL_ZERO))
						state_d = ST_SLEEP;
					else
						state_d = ST_TAIL;
				end
			end
			ST_TAIL:
			begin
				if (!sleep_req_q || irq_pending)
					state_d = ST_RUN;
				else if (mcu_rise && (tail_cnt_q == DIV_ONE))
					state_d = ST_SLEEP;
			end
			ST_SLEEP:
			begin
				if (!sleep_req_q || irq_pending)
					state_d = ST_RUN;
			end
			default: state_d = ST_RUN;
		endcase
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			state_q <= ST_RUN;
		else if (chip_rst_q)
			state_q <= ST_RUN;
		else
			state_q <= state_d;
	end

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			tail_cnt_q <= TAIL_ZERO;
		else if (state_q == ST_RUN)
			tail_cnt_q <= TAIL_CYCLES[clk_ctrl_q.clkt];
		else if (state_q == ST_TAIL && mcu_rise && tail_cnt_q != TAIL_ZERO)
			tail_cnt_q <= tail_cnt_q - 1'b1;
	end

	// Crystal is stopped only once the sleep state is really reached
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			xtal_en_q <= 1'b1;
		else
			xtal_en_q <= (state_d != ST_SLEEP) || chip_rst_q;
	end

	// Source choice moves when unused, or while both slow clocks and the output are low
	// Both low means the new source starts with a whole high phase
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			lf_sel_q <= 1'b0;
		else if (src_q != SRC_LF || (!mcu_clk_q && !rc_s && !x32_s))
			lf_sel_q <= clk_ctrl_q.x32k_sel;
	end

	assign lf_now  = lf_sel_q ? x32_s : rc_s;
	assign lf_rise = lf_now && !lf_prev_q;
	assign lf_fall = !lf_now && lf_prev_q;

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			lf_prev_q <= 1'b0;
		else
			lf_prev_q <= lf_now;
	end

	// Wanted source from mode and select
	always_comb
	begin
		src_want = SRC_XTAL;
		if (state_q == ST_SLEEP)
			src_want = clk_ctrl_q.enlfc ? SRC_LF : SRC_OFF;
		else if (clk_ctrl_q.mclk == MCLK_LF_SEL)
			src_want = SRC_LF;
		if (!xtal_en_q && src_want == SRC_XTAL)
			src_want = SRC_OFF;
	end

	// Switching while low means every high phase is whole
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			src_q  <= SRC_XTAL;
			half_q <= HALF_PERIOD[MCLK_1MHZ_SEL];
		end
		else if (!mcu_clk_q && (src_q != src_want || xtal_toggle || src_q != SRC_XTAL))
		begin
			src_q  <= src_want;
			half_q <= HALF_PERIOD[clk_ctrl_q.mclk];
		end
	end

	assign xtal_toggle = (src_q == SRC_XTAL) && (div_cnt_q == half_q - DIV_ONE);

	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			div_cnt_q <= '0;
		else if (src_q != SRC_XTAL || xtal_toggle || (!mcu_clk_q && src_q != src_want))
			div_cnt_q <= '0;
		else
			div_cnt_q <= div_cnt_q + DIV_ONE;
	end

	assign mcu_rise = !mcu_clk_q && (src_q == src_want)
		&& (((src_q == SRC_XTAL) && xtal_toggle) || ((src_q == SRC_LF) && lf_rise));

	// Output phase; select 000 uses the shortest half period
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
			mcu_clk_q <= 1'b0;
		else if (mcu_clk_q)
		begin
			if ((src_q == SRC_XTAL && xtal_toggle) || (src_q == SRC_LF && lf_fall)
				|| src_q == SRC_OFF)
				mcu_clk_q <= 1'b0;
		end
		else if (mcu_rise)
			mcu_clk_q <= 1'b1;
	end

	// General-purpose pins
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			gp_pin_a_q <= 1'b1;
			gp_pin_b_q <= 1'b0;
			gp_pin_c_q <= 1'b0;
		end
		else
		begin
			gp_pin_a_q <= gp_ctrl_q[GP_A_BIT] ? chip_rst_q : 1'b0;
			gp_pin_b_q <= gp_ctrl_q[GP_B_BIT] ? !chip_rst_q : 1'b0;
			gp_pin_c_q <= gp_ctrl_q[GP_C_BIT] ? mcu_clk_q : 1'b0;
		end
	end
endmodule

// File: verif/mcu_clk_monitor.sv
// Concurrent checks on the clock and reset output block ports
`timescale 1ns/1ps
module mcu_clk_monitor
	import mcu_clk_pkg::*;
(
	input wire logic       core_clk,
	input wire logic       resetn,
	input wire bus_req_t   bus_req,
	input wire logic [7:0] rd_data_q,
	input wire logic [7:0] int_status_a,
	input wire logic [7:0] int_status_b,
	input wire logic       irq_pending,
	input wire logic       int_status_a_rd_q,
	input wire logic       int_status_b_rd_q,
	input wire logic       supply_low,
	input wire logic       xtal_en_q,
	input wire logic       chip_rst_q,
	input wire logic       gp_pin_a_q,
	input wire logic       gp_pin_b_q,
	input wire logic       gp_pin_c_q
);
	logic [11:0] run_q;
	logic        soft_q;
	logic        swr;
	assign swr = bus_req.wr && bus_req.addr == ADDR_MODE_CTRL && bus_req.wdata[MODE_SOFT_RST_BIT];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Only software-started runs are timed; power-up runs vary with the synchroniser
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			run_q  <= '0;
			soft_q <= 1'b0;
		end
		else
		begin
			run_q  <= chip_rst_q ? run_q + 12'h001 : 12'h000;
			soft_q <= swr || (soft_q && (chip_rst_q || run_q == 12'h000));
		end
	end
	sequence s_soft_wr;
		swr;
	endsequence
	sequence s_rst_held;
		chip_rst_q [*8];
	endsequence
	property p_soft_start;
		s_soft_wr |=> s_rst_held;
	endproperty
	property p_soft_len;
		soft_q && $fell(chip_rst_q) |-> run_q >= SOFT_RESET_CYCLES
			&& run_q <= SOFT_RESET_CYCLES + 3;
	endproperty
	property p_pin_a;
		chip_rst_q [*3] |-> gp_pin_a_q;
	endproperty
	property p_pin_b;
		chip_rst_q [*3] |-> !gp_pin_b_q;
	endproperty
	property p_supply;
		supply_low [*5] |-> chip_rst_q;
	endproperty
	property p_irq_hold;
		irq_pending [*4] |-> xtal_en_q;
	endproperty
	property p_xtal_fall;
		$fell(xtal_en_q) |-> !$past(irq_pending);
	endproperty
	property p_ack_a;
		bus_req.rd && bus_req.addr == ADDR_INT_STATUS_A && !chip_rst_q
			|=> int_status_a_rd_q && rd_data_q == $past(int_status_a);
	endproperty
	property p_ack_b;
		bus_req.rd && bus_req.addr == ADDR_INT_STATUS_B && !chip_rst_q
			|=> int_status_b_rd_q && rd_data_q == $past(int_status_b);
	endproperty
	property p_clk_start;
		$fell(chip_rst_q) |-> ##[1:60] $rose(gp_pin_c_q);
	endproperty
	a_soft_start: assert property (p_soft_start) else $error("soft reset not held");
	a_soft_len: assert property (p_soft_len) else $error("soft reset length wrong");
	a_pin_a: assert property (p_pin_a) else $error("pin a not showing reset");
	a_pin_b: assert property (p_pin_b) else $error("pin b not inverted reset");
	a_supply: assert property (p_supply) else $error("supply drop without reset");
	a_irq_hold: assert property (p_irq_hold) else $error("crystal off with irq");
	a_xtal_fall: assert property (p_xtal_fall) else $error("crystal stopped on irq");
	a_ack_a: assert property (p_ack_a) else $error("status read wrong");
	a_ack_b: assert property (p_ack_b) else $error("second status read wrong");
	a_clk_start: assert property (p_clk_start) else $error("no clock after reset");
endmodule

bind mcu_clock_and_reset_output mcu_clk_monitor u_mon (.core_clk, .resetn, .bus_req,
	.rd_data_q, .int_status_a, .int_status_b, .irq_pending, .int_status_a_rd_q,
	.int_status_b_rd_q, .supply_low, .xtal_en_q,
	.chip_rst_q, .gp_pin_a_q, .gp_pin_b_q, .gp_pin_c_q);

// File: verif/mcu_clk_sink.sv
// Microcontroller side: measures high phase and rising edges of its clock
`timescale 1ns/1ps
module mcu_clk_sink (
	input wire logic        core_clk,
	input wire logic        resetn,
	input wire logic        mcu_clk,
	output logic     [7:0]  half_q,
	output logic     [15:0] edges_q
);
	logic [7:0] cnt_q;
	logic       prev_q;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			cnt_q   <= '0;
			prev_q  <= 1'b0;
			half_q  <= '0;
			edges_q <= '0;
		end
		else
		begin
			cnt_q   <= mcu_clk ? cnt_q + 8'h01 : 8'h00;
			prev_q  <= mcu_clk;
			half_q  <= (prev_q && !mcu_clk) ? cnt_q : half_q;
			edges_q <= edges_q + {15'h0000, mcu_clk && !prev_q};
		end
	end
endmodule

// File: verif/testbench.sv
// Self-checking bench for the clock and reset output block
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin errors++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench
	import mcu_clk_pkg::*;
;
	logic        core_clk = 1'b0, resetn = 1'b0, irq_pending = 1'b0, rd_v = 1'b0;
	logic        rc_32k_clk = 1'b0, xtal_32k_clk = 1'b0, por_ready = 1'b1, supply_low = 1'b0;
	bus_req_t    bus_req = '0;
	logic [7:0]  int_status_a = 8'h00, int_status_b = 8'h00, rd_data_q, half, e_v;
	logic        int_status_a_rd_q, int_status_b_rd_q, xtal_en_q, chip_rst_q;
	logic        gp_pin_a_q, gp_pin_b_q, gp_pin_c_q;
	logic [15:0] edges, e0;
	logic [7:0]  exp_q [$];
	logic [31:0] seed = 32'hec7a_ab88;
	int          errors = 0, checks = 0, cyc = 0, n;
	mcu_clock_and_reset_output uut (.core_clk, .resetn, .bus_req, .rd_data_q, .int_status_a,
		.int_status_b, .irq_pending, .int_status_a_rd_q, .int_status_b_rd_q, .rc_32k_clk,
		.xtal_32k_clk, .por_ready, .supply_low, .xtal_en_q, .chip_rst_q, .gp_pin_a_q,
		.gp_pin_b_q, .gp_pin_c_q);
	mcu_clk_sink u_sink (.core_clk, .resetn, .mcu_clk(gp_pin_c_q), .half_q(half), .edges_q(edges));
	always #20 core_clk = ~core_clk;
	// Slow clocks toggle on falling core edges, never on the sampling edge
	always #800 rc_32k_clk = ~rc_32k_clk;
	always #1200 xtal_32k_clk = ~xtal_32k_clk;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic tick(input int k);
		repeat (k) @(posedge core_clk);
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		if (!w)
			exp_q.push_back(d);
		@(posedge core_clk);
		bus_req <= '{addr: a, wdata: w ? d : 8'h00, wr: w, rd: !w};
		@(posedge core_clk);
		bus_req <= '0;
	endtask
	task automatic wait_run();
		n = 0;
		while (chip_rst_q !== 1'b0 && n < 200)
		begin
			@(posedge core_clk);
			n++;
		end
	endtask
	task automatic conclude();
		if (errors == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	always @(posedge core_clk)
	begin
		if (rd_v)
		begin
			e_v = exp_q.pop_front();
			`CHK("rd_data_q", e_v, rd_data_q)
		end
		rd_v <= bus_req.rd;
		cyc++;
		if (cyc == 20000)
		begin
			errors++;
			conclude();
		end
	end
	initial
	begin
		tick(8);
		resetn <= 1'b1;
		wait_run();
		xfer(0, ADDR_CLK_CTRL, {1'b0, CLK_CTRL_RST});
		xfer(0, ADDR_GP_CTRL, {5'h00, GP_CTRL_RST});
		xfer(0, 8'h40, READ_ZERO);
		tick(60);
		`CHK("half", HALF_PERIOD[MCLK_1MHZ_SEL], half)
		`CHK("gp_ab", 2'b01, {gp_pin_a_q, gp_pin_b_q})
		for (int s = 0; s < 7; s++)
		begin
			xfer(1, ADDR_CLK_CTRL, 8'(s));
			tick(60);
			`CHK("half", HALF_PERIOD[s], half)
		end
		for (int x = 0; x < 2; x++)
		begin
			xfer(1, ADDR_CLK_CTRL, x ? 8'h47 : 8'h07);
			tick(200);
			`CHK("lf_half", 1'b1, half inside {[19 + 10 * x : 21 + 10 * x]})
		end
		for (int i = 0; i < 4; i++)
		begin
			seed = lfsr(seed);
			int_status_a <= seed[7:0];
			int_status_b <= seed[15:8];
			xfer(0, ADDR_INT_STATUS_A, seed[7:0]);
			xfer(0, ADDR_INT_STATUS_B, seed[15:8]);
		end
		xfer(1, ADDR_CLK_CTRL, 8'h20);
		xfer(1, ADDR_MODE_CTRL, 8'h01);
		tick(150);
		`CHK("xtal_en", 1'b0, xtal_en_q)
		`CHK("lf_half", 1'b1, half inside {[19:21]})
		xfer(0, ADDR_STATUS, 8'h0A);
		xfer(1, ADDR_MODE_CTRL, 8'h00);
		tick(10);
		`CHK("xtal_en", 1'b1, xtal_en_q)
		for (int t = 0; t < 4; t++)
		begin
			xfer(1, ADDR_CLK_CTRL, 8'(t << 3));
			e0 = edges;
			xfer(1, ADDR_MODE_CTRL, 8'h01);
			tick(120);
			`CHK("tail", 1'b1, edges - e0 - TAIL_CYCLES[t] <= 3)
			`CHK("stopped", 2'b00, {gp_pin_c_q, xtal_en_q})
			xfer(1, ADDR_MODE_CTRL, 8'h00);
		end
		xfer(1, ADDR_CLK_CTRL, 8'h20);
		irq_pending <= 1'b1;
		xfer(1, ADDR_MODE_CTRL, 8'h01);
		tick(20);
		`CHK("xtal_en", 1'b1, xtal_en_q)
		`CHK("half", HALF_PERIOD[MCLK_FULL_SEL], half)
		xfer(0, ADDR_STATUS, 8'h14);
		xfer(0, ADDR_INT_STATUS_A, int_status_a);
		xfer(0, ADDR_INT_STATUS_B, int_status_b);
		irq_pending <= 1'b0;
		tick(20);
		`CHK("xtal_en", 1'b0, xtal_en_q)
		irq_pending <= 1'b1;
		tick(10);
		`CHK("xtal_en", 1'b1, xtal_en_q)
		irq_pending <= 1'b0;
		xfer(1, ADDR_MODE_CTRL, 8'h00);
		xfer(1, ADDR_GP_CTRL, 8'h00);
		tick(30);
		`CHK("gp_off", 3'b000, {gp_pin_a_q, gp_pin_b_q, gp_pin_c_q})
		xfer(1, ADDR_GP_CTRL, {5'h00, GP_CTRL_RST});
		xfer(1, ADDR_CLK_CTRL, 8'h3D);
		xfer(1, ADDR_MODE_CTRL, 8'h02);
		tick(2);
		`CHK("soft_rst", 2'b11, {chip_rst_q, gp_pin_a_q})
		wait_run();
		`CHK("soft_len", 1'b1, n inside {[SOFT_RESET_CYCLES - 4 : SOFT_RESET_CYCLES + 1]})
		xfer(0, ADDR_CLK_CTRL, {1'b0, CLK_CTRL_RST});
		tick(60);
		xfer(1, ADDR_CLK_CTRL, 8'h3D);
		supply_low <= 1'b1;
		por_ready <= 1'b0;
		tick(10);
		`CHK("drop_rst", 2'b10, {chip_rst_q, gp_pin_b_q})
		supply_low <= 1'b0;
		tick(20);
		`CHK("drop_rst", 1'b1, chip_rst_q)
		por_ready <= 1'b1;
		wait_run();
		xfer(0, ADDR_CLK_CTRL, {1'b0, CLK_CTRL_RST});
		tick(4);
		conclude();
	end
endmodule
